// ===== rtl/cvdsq_pkg.sv
package cvdsq_pkg;
  localparam int ADDR_W = 12;
  // Register byte offsets
  localparam logic [11:0] OFF_CTRL0_1  = 12'h000;
  localparam logic [11:0] OFF_CTRL0_2  = 12'h004;
  localparam logic [11:0] OFF_COMMON   = 12'h008;
  localparam logic [11:0] OFF_TRIG     = 12'h00C;
  localparam logic [11:0] OFF_SEQ1     = 12'h010;
  localparam logic [11:0] OFF_SEQ2     = 12'h014;
  localparam logic [11:0] OFF_RES1_0   = 12'h018;
  localparam logic [11:0] OFF_RES1_1   = 12'h01C;
  localparam logic [11:0] OFF_RES2_0   = 12'h020;
  localparam logic [11:0] OFF_RES2_1   = 12'h024;
  localparam logic [11:0] OFF_IRQ_STAT = 12'h028;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h02C;
  localparam logic [11:0] OFF_PHASE    = 12'h030;
  // Control0 fields
  localparam int CTL0_ENABLE_BIT = 0;
  localparam int CTL0_GO_BIT     = 1;
  localparam int CTL0_CHAN_LSB   = 2;
  // Common control fields
  localparam int COM_GO_ALL_BIT  = 2;
  localparam int COM_JUSTIFY_BIT = 7;
  // Sequencer config fields: [6:0] precharge, [14:8] acquire, 16..22 flags
  localparam int SEQ_PRE_LSB     = 0;
  localparam int SEQ_ACQ_LSB     = 8;
  localparam int SEQ_DOUBLE_BIT  = 16;
  localparam int SEQ_INVERT_BIT  = 17;
  localparam int SEQ_CAPPOL_BIT  = 18;
  localparam int SEQ_PADPOL_BIT  = 19;
  localparam int SEQ_GRDPOL_BIT  = 20;
  localparam int SEQ_GRDAOE_BIT  = 21;
  localparam int SEQ_GRDBOE_BIT  = 22;
  localparam int CNT_W           = 7;
  localparam int RES_W           = 10;
  localparam int CONV_CYCLES     = 11;
  localparam int GAP_CYCLES      = 2;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  typedef enum logic [2:0] {
    CVDSQ_IDLE = 3'b000,
    CVDSQ_PRE  = 3'b001,
    CVDSQ_ACQ  = 3'b010,
    CVDSQ_CONV = 3'b011,
    CVDSQ_GAP  = 3'b100
  } cvdsq_state_e;

  typedef struct packed {
    logic       enable;
    logic       dbl;
    logic       invert;
    logic       cap_pol;
    logic       pad_pol;
    logic       grd_pol;
    logic       grd_a_oe;
    logic       grd_b_oe;
    logic [6:0] pre_cnt;
    logic [6:0] acq_cnt;
  } cvdsq_cfg_s;

  typedef struct packed {
    logic hold_isolate;
    logic hold_to_vdd;
    logic pad_drive_oe;
    logic pad_drive_hi;
    logic conv_start;
    logic grd_a_o;
    logic grd_a_oe;
    logic grd_b_o;
    logic grd_b_oe;
  } cvdsq_analog_s;
endpackage

// ===== rtl/cvdsq_result_store.sv
`timescale 1ns/100ps
module cvdsq_result_store #(
  parameter int W = 10
) (
  input  wire logic         clk_sys_i,
  input  wire logic         nrst_i,
  input  wire logic         ce_i,
  input  wire logic         wr_i,
  input  wire logic         sel_i,
  input  wire logic [W-1:0] data_i,
  output logic      [W-1:0] res0_o,
  output logic      [W-1:0] res1_o
);
  logic [W-1:0] res0_q;
  logic [W-1:0] res1_q;
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      res0_q <= '0;
      res1_q <= '0;
    end else if (ce_i && wr_i) begin
      if (sel_i) begin
        res1_q <= data_i;
      end else begin
        res0_q <= data_i;
      end
    end
  end
  assign res0_o = res0_q;
  assign res1_o = res1_q;
endmodule // cvdsq_result_store

// ===== rtl/cvdsq_seq.sv
`timescale 1ns/100ps
module cvdsq_seq (
  input  wire logic                  clk_sys_i,
  input  wire logic                  nrst_i,
  input  wire logic                  ce_i,
  input  wire logic                  start_i,
  input  wire logic                  abort_i,
  input  wire cvdsq_pkg::cvdsq_cfg_s cfg_i,
  input  wire logic [9:0]            sample_i,
  output cvdsq_pkg::cvdsq_analog_s   ana_o,
  output logic                       busy_o,
  output logic                       done_o,
  output logic                       res_wr_o,
  output logic                       res_sel_o,
  output logic [9:0]                 res_o,
  output logic [2:0]                 phase_o
);
  cvdsq_pkg::cvdsq_state_e state_q, state_d;
  logic [6:0] cnt_q, cnt_d;
  logic       second_q, second_d;
  logic [9:0] res_q;
  logic       wr_q;
  logic       done_q;
  logic       sel_q;
  logic       grd_lvl_q;

  wire inv_now   = second_q & cfg_i.invert;
  wire cap_lvl   = cfg_i.cap_pol ^ inv_now;
  wire pad_lvl   = cfg_i.pad_pol ^ inv_now;
  wire pre_zero  = (cfg_i.pre_cnt == 7'h00);
  wire acq_zero  = (cfg_i.acq_cnt == 7'h00);
  wire cnt_last  = (cnt_q == 7'h01) | (cnt_q == 7'h00);
  wire in_pre    = (state_q == cvdsq_pkg::CVDSQ_PRE);
  wire conv_end  = (state_q == cvdsq_pkg::CVDSQ_CONV) & cnt_last;

  always_comb begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    second_d = second_q;
    unique case (state_q)
      cvdsq_pkg::CVDSQ_IDLE: begin
        second_d = 1'b0;
        if (start_i && cfg_i.enable) begin
          if (!pre_zero) begin
            state_d = cvdsq_pkg::CVDSQ_PRE;
            cnt_d   = cfg_i.pre_cnt;
          end else begin
            state_d = cvdsq_pkg::CVDSQ_ACQ;
            cnt_d   = cfg_i.acq_cnt;
          end
        end
      end
      cvdsq_pkg::CVDSQ_PRE: begin
        cnt_d = cnt_q - 7'h01;
        if (cnt_last) begin
          state_d = cvdsq_pkg::CVDSQ_ACQ;
          cnt_d   = cfg_i.acq_cnt;
        end
      end
      cvdsq_pkg::CVDSQ_ACQ: begin
        cnt_d = cnt_q - 7'h01;
        if (cnt_last || acq_zero) begin
          state_d = cvdsq_pkg::CVDSQ_CONV;
          cnt_d   = 7'(pkg_conv());
        end
      end
      cvdsq_pkg::CVDSQ_CONV: begin
        cnt_d = cnt_q - 7'h01;
        if (cnt_last) begin
          if (cfg_i.dbl && !second_q) begin
            state_d  = cvdsq_pkg::CVDSQ_GAP;
            cnt_d    = 7'(cvdsq_pkg::GAP_CYCLES);
            second_d = 1'b1;
          end else begin
            state_d = cvdsq_pkg::CVDSQ_IDLE;
          end
        end
      end
      cvdsq_pkg::CVDSQ_GAP: begin
        cnt_d = cnt_q - 7'h01;
        if (cnt_last) begin
          state_d = pre_zero ? cvdsq_pkg::CVDSQ_ACQ : cvdsq_pkg::CVDSQ_PRE;
          cnt_d   = pre_zero ? cfg_i.acq_cnt : cfg_i.pre_cnt;
        end
      end
      default: state_d = cvdsq_pkg::CVDSQ_IDLE;
    endcase
    if (abort_i || !cfg_i.enable) begin
      state_d = cvdsq_pkg::CVDSQ_IDLE;
    end
  end

  function automatic int pkg_conv();
    return cvdsq_pkg::CONV_CYCLES;
  endfunction

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q  <= cvdsq_pkg::CVDSQ_IDLE;
      cnt_q    <= 7'h00;
      second_q <= 1'b0;
    end else if (ce_i) begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      second_q <= second_d;
    end
  end

  // Result captured at conversion end; hold cap left as is afterwards
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      res_q  <= '0;
      wr_q   <= 1'b0;
      done_q <= 1'b0;
      sel_q  <= 1'b0;
    end else if (ce_i) begin
      wr_q   <= conv_end;
      done_q <= conv_end & ~(cfg_i.dbl & ~second_q);
      if (conv_end) begin
        res_q <= sample_i;
        // Second flag flips with the gap, so the set is latched here
        sel_q <= second_q;
      end
    end
  end

  // Guard flips at acquisition start; initialised at precharge
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      grd_lvl_q <= 1'b0;
    end else if (ce_i) begin
      if (state_d == cvdsq_pkg::CVDSQ_PRE && !in_pre) begin
        grd_lvl_q <= cfg_i.grd_pol ^ second_d & cfg_i.invert;
      end else if (state_d == cvdsq_pkg::CVDSQ_ACQ
                   && state_q != cvdsq_pkg::CVDSQ_ACQ) begin
        grd_lvl_q <= ~(cfg_i.grd_pol ^ (second_d & cfg_i.invert));
      end
    end
  end

  // Hold cap is isolated only in precharge; no discharge otherwise
  assign ana_o.hold_isolate = in_pre;
  assign ana_o.hold_to_vdd  = in_pre & cap_lvl;
  assign ana_o.pad_drive_oe = in_pre;
  assign ana_o.pad_drive_hi = pad_lvl;
  assign ana_o.conv_start   = (state_q == cvdsq_pkg::CVDSQ_CONV);
  assign ana_o.grd_a_o      = grd_lvl_q;
  assign ana_o.grd_a_oe     = cfg_i.enable & cfg_i.grd_a_oe;
  assign ana_o.grd_b_o      = grd_lvl_q;
  assign ana_o.grd_b_oe     = cfg_i.enable & cfg_i.grd_b_oe;
  assign busy_o    = (state_q != cvdsq_pkg::CVDSQ_IDLE);
  assign done_o    = done_q;
  assign res_wr_o  = wr_q;
  assign res_sel_o = sel_q;
  assign res_o     = res_q;
  assign phase_o   = state_q;

  sequence s_gap_entry;
    (state_q == cvdsq_pkg::CVDSQ_CONV)
      ##1 (state_q == cvdsq_pkg::CVDSQ_GAP && !abort_i && cfg_i.enable);
  endsequence
  sequence s_gap_exit;
    (state_q == cvdsq_pkg::CVDSQ_GAP) ##1 (state_q != cvdsq_pkg::CVDSQ_GAP);
  endsequence
  a_gap_two: assert property (@(posedge clk_sys_i) disable iff (!nrst_i || !ce_i)
    s_gap_entry |=> s_gap_exit) else $error("gap not two cycles");
endmodule // cvdsq_seq

// ===== rtl/cvdsq_top.sv
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/100ps
module cvdsq_top (
  input  wire logic                clk_sys_i,
  input  wire logic                nrst_i,
  input  wire logic                ce_i,
  input  wire logic                psel_i,
  input  wire logic                penable_i,
  input  wire logic                pwrite_i,
  input  wire logic [11:0]         paddr_i,
  input  wire logic [31:0]         pwdata_i,
  output logic      [31:0]         prdata_o,
  output logic                     pready_o,
  output logic                     pslverr_o,
  input  wire logic [9:0]          sample1_i,
  input  wire logic [9:0]          sample2_i,
  output cvdsq_pkg::cvdsq_analog_s ana1_o,
  output cvdsq_pkg::cvdsq_analog_s ana2_o,
  output logic [4:0]               chan1_o,
  output logic [4:0]               chan2_o,
  output logic [2:0]               clk_sel_o,
  output logic [1:0]               ref_sel_o,
  output logic [2:0]               trig_sel_o,
  output logic                     irq_o
);
  logic [7:0]  ctl1_q, ctl2_q, com_q, trig_q;
  logic [22:0] seq1_q, seq2_q;
  logic [1:0]  stat_q, mask_q;
  logic        go1_q, go2_q;

  wire wr_en  = psel_i & penable_i & pwrite_i & ce_i;
  wire hit_c1 = (paddr_i == cvdsq_pkg::OFF_CTRL0_1);
  wire hit_c2 = (paddr_i == cvdsq_pkg::OFF_CTRL0_2);
  wire hit_cm = (paddr_i == cvdsq_pkg::OFF_COMMON);
  wire hit_tr = (paddr_i == cvdsq_pkg::OFF_TRIG);
  wire hit_s1 = (paddr_i == cvdsq_pkg::OFF_SEQ1);
  wire hit_s2 = (paddr_i == cvdsq_pkg::OFF_SEQ2);
  wire hit_st = (paddr_i == cvdsq_pkg::OFF_IRQ_STAT);
  wire hit_mk = (paddr_i == cvdsq_pkg::OFF_IRQ_MASK);

  // Go-all starts both sequencers in the same cycle
  wire go_all = wr_en & hit_cm & pwdata_i[cvdsq_pkg::COM_GO_ALL_BIT];
  wire start1 = (wr_en & hit_c1 & pwdata_i[cvdsq_pkg::CTL0_GO_BIT]) | go_all;
  wire start2 = (wr_en & hit_c2 & pwdata_i[cvdsq_pkg::CTL0_GO_BIT]) | go_all;
  // Clearing go by software terminates the conversion
  wire abort1 = wr_en & hit_c1 & ~pwdata_i[cvdsq_pkg::CTL0_GO_BIT];
  wire abort2 = wr_en & hit_c2 & ~pwdata_i[cvdsq_pkg::CTL0_GO_BIT];

  function automatic cvdsq_pkg::cvdsq_cfg_s mk_cfg(input logic en, input logic [22:0] s);
    mk_cfg.enable   = en;
    mk_cfg.dbl      = s[cvdsq_pkg::SEQ_DOUBLE_BIT];
    mk_cfg.invert   = s[cvdsq_pkg::SEQ_INVERT_BIT];
    mk_cfg.cap_pol  = s[cvdsq_pkg::SEQ_CAPPOL_BIT];
    mk_cfg.pad_pol  = s[cvdsq_pkg::SEQ_PADPOL_BIT];
    mk_cfg.grd_pol  = s[cvdsq_pkg::SEQ_GRDPOL_BIT];
    mk_cfg.grd_a_oe = s[cvdsq_pkg::SEQ_GRDAOE_BIT];
    mk_cfg.grd_b_oe = s[cvdsq_pkg::SEQ_GRDBOE_BIT];
    mk_cfg.pre_cnt  = s[cvdsq_pkg::SEQ_PRE_LSB +: 7];
    mk_cfg.acq_cnt  = s[cvdsq_pkg::SEQ_ACQ_LSB +: 7];
  endfunction

  wire cvdsq_pkg::cvdsq_cfg_s cfg1 = mk_cfg(ctl1_q[cvdsq_pkg::CTL0_ENABLE_BIT], seq1_q);
  wire cvdsq_pkg::cvdsq_cfg_s cfg2 = mk_cfg(ctl2_q[cvdsq_pkg::CTL0_ENABLE_BIT], seq2_q);

  logic       busy1, busy2, done1, done2, wr1, wr2, sel1, sel2;
  logic [9:0] r1, r2, r10, r11, r20, r21;
  logic [2:0] ph1, ph2;

  cvdsq_seq u_seq1 (
    .clk_sys_i (clk_sys_i), .nrst_i (nrst_i), .ce_i (ce_i),
    .start_i (start1), .abort_i (abort1), .cfg_i (cfg1), .sample_i (sample1_i),
    .ana_o (ana1_o), .busy_o (busy1), .done_o (done1), .res_wr_o (wr1),
    .res_sel_o (sel1), .res_o (r1), .phase_o (ph1)
  );
  cvdsq_seq u_seq2 (
    .clk_sys_i (clk_sys_i), .nrst_i (nrst_i), .ce_i (ce_i),
    .start_i (start2), .abort_i (abort2), .cfg_i (cfg2), .sample_i (sample2_i),
    .ana_o (ana2_o), .busy_o (busy2), .done_o (done2), .res_wr_o (wr2),
    .res_sel_o (sel2), .res_o (r2), .phase_o (ph2)
  );
  cvdsq_result_store #(.W(cvdsq_pkg::RES_W)) u_res1 (
    .clk_sys_i (clk_sys_i), .nrst_i (nrst_i), .ce_i (ce_i), .wr_i (wr1),
    .sel_i (sel1), .data_i (r1), .res0_o (r10), .res1_o (r11)
  );
  cvdsq_result_store #(.W(cvdsq_pkg::RES_W)) u_res2 (
    .clk_sys_i (clk_sys_i), .nrst_i (nrst_i), .ce_i (ce_i), .wr_i (wr2),
    .sel_i (sel2), .data_i (r2), .res0_o (r20), .res1_o (r21)
  );

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctl1_q <= 8'h00;
      ctl2_q <= 8'h00;
      com_q  <= 8'h00;
      trig_q <= 8'h00;
      seq1_q <= 23'h000000;
      seq2_q <= 23'h000000;
      mask_q <= 2'h0;
    end else if (wr_en) begin
      if (hit_c1) ctl1_q <= pwdata_i[7:0];
      if (hit_c2) ctl2_q <= pwdata_i[7:0];
      if (hit_cm) com_q  <= pwdata_i[7:0];
      if (hit_tr) trig_q <= pwdata_i[7:0];
      if (hit_s1) seq1_q <= pwdata_i[22:0];
      if (hit_s2) seq2_q <= pwdata_i[22:0];
      if (hit_mk) mask_q <= pwdata_i[1:0];
    end
  end

  // Done flags: set wins over write-one-to-clear
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stat_q <= 2'h0;
    end else if (ce_i) begin
      stat_q <= (stat_q & ~(wr_en & hit_st ? pwdata_i[1:0] : 2'h0))
                | {done2, done1};
    end
  end

  wire [9:0] d1 = com_q[cvdsq_pkg::COM_JUSTIFY_BIT] ? r10 : r10;
  wire [31:0] ctl1_rd = {24'h000000, ctl1_q[7:2], busy1, ctl1_q[0]};
  wire [31:0] ctl2_rd = {24'h000000, ctl2_q[7:2], busy2, ctl2_q[0]};
  wire [31:0] com_rd  = {24'h000000, com_q[7:3], busy1 | busy2, com_q[1:0]};

  always_comb begin
    unique case (paddr_i)
      cvdsq_pkg::OFF_CTRL0_1:  prdata_o = ctl1_rd;
      cvdsq_pkg::OFF_CTRL0_2:  prdata_o = ctl2_rd;
      cvdsq_pkg::OFF_COMMON:   prdata_o = com_rd;
      cvdsq_pkg::OFF_TRIG:     prdata_o = {24'h000000, 1'b0, trig_q[6:4], 4'h0};
      cvdsq_pkg::OFF_SEQ1:     prdata_o = {9'h000, seq1_q};
      cvdsq_pkg::OFF_SEQ2:     prdata_o = {9'h000, seq2_q};
      cvdsq_pkg::OFF_RES1_0:   prdata_o = {22'h000000, d1};
      cvdsq_pkg::OFF_RES1_1:   prdata_o = {22'h000000, r11};
      cvdsq_pkg::OFF_RES2_0:   prdata_o = {22'h000000, r20};
      cvdsq_pkg::OFF_RES2_1:   prdata_o = {22'h000000, r21};
      cvdsq_pkg::OFF_IRQ_STAT: prdata_o = {30'h00000000, stat_q};
      cvdsq_pkg::OFF_IRQ_MASK: prdata_o = {30'h00000000, mask_q};
      cvdsq_pkg::OFF_PHASE:    prdata_o = {26'h0000000, ph2, ph1};
      default:                 prdata_o = 32'h0000_0000;
    endcase
  end

  wire mapped = (paddr_i <= cvdsq_pkg::OFF_PHASE) & (paddr_i[1:0] == 2'b00);
  assign pready_o   = 1'b1;
  assign pslverr_o  = psel_i & penable_i & ~mapped;
  assign irq_o      = |(stat_q & mask_q);
  assign chan1_o    = ctl1_q[cvdsq_pkg::CTL0_CHAN_LSB +: 5];
  assign chan2_o    = ctl2_q[cvdsq_pkg::CTL0_CHAN_LSB +: 5];
  assign clk_sel_o  = com_q[6:4];
  assign ref_sel_o  = com_q[1:0];
  assign trig_sel_o = trig_q[6:4];

  a_busy_done: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    $rose(done1) |-> !busy1) else $error("busy still set at done");
  a_irq_level: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    done1 && mask_q[0] && ce_i && !(wr_en && hit_mk) |=> irq_o)
    else $error("irq mismatch");
  a_pre_isol: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    ana1_o.hold_isolate |-> ana1_o.pad_drive_oe) else $error("pad not driven");
  a_acq_release: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    $fell(ana1_o.hold_isolate) && busy1 |-> !ana1_o.pad_drive_oe
      && ph1 == cvdsq_pkg::CVDSQ_ACQ) else $error("drive");
  a_both_start: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    go_all && ce_i && cfg1.enable && cfg2.enable |=> busy1 && busy2) else $error("sync");
  a_start_busy: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    start1 && ce_i && cfg1.enable && !abort1 |=> busy1) else $error("no start");
  a_done_store: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    done1 |-> wr1) else $error("no store");
  a_no_hold: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    !busy1 |-> !ana1_o.hold_isolate) else $error("idle drive");
endmodule // cvdsq_top

// ===== dv/cvdsq_pad_model.sv
`timescale 1ns/100ps
module cvdsq_pad_model (
  input  wire logic                     clk_sys_i,
  input  wire logic                     nrst_i,
  input  wire cvdsq_pkg::cvdsq_analog_s ana_i,
  output logic [9:0]                    sample_o
);
  logic       cap_hi_q;
  logic [9:0] share;
  // Charge kept between runs, nothing bleeds it off
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cap_hi_q <= 1'b0;
    end else if (ana_i.hold_isolate) begin
      cap_hi_q <= ana_i.hold_to_vdd;
    end
  end
  assign share    = cap_hi_q ? 10'h2A5 : 10'h15A;
  // Outside conversion the line shows garbage, not the last value
  assign sample_o = ana_i.conv_start ? share : ~share;
endmodule // cvdsq_pad_model

// ===== dv/testbench.sv
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin n_fail++; \
  $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module testbench;
  logic                     clk_sys_i = 1'b0;
  logic                     nrst_i    = 1'b0;
  logic                     ce        = 1'b1;
  logic                     psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0]              paddr  = 12'h000;
  logic [31:0]              pwdata = 32'h0000_0000;
  logic [31:0]              prdata, r;
  logic                     pready, pslverr, irq, e, pl;
  logic [9:0]               s1, s2;
  cvdsq_pkg::cvdsq_analog_s a1, a2;
  logic [4:0]               ch1;
  int                       n_fail = 0, tests_run = 0, cyc = 0;
  int                       n_iso, n_acq, n_conv, n_bad, n_skew;
  logic                     acq_on = 1'b0, prev_iso = 1'b0, g_pre, g_acq;
  logic                     pol[$];

  always #10 clk_sys_i = ~clk_sys_i;

  cvdsq_top uut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .ce_i(ce), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .sample1_i(s1),
    .sample2_i(s2), .ana1_o(a1), .ana2_o(a2), .chan1_o(ch1), .chan2_o(),
    .clk_sel_o(), .ref_sel_o(), .trig_sel_o(), .irq_o(irq));
  cvdsq_pad_model pad1 (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .ana_i(a1), .sample_o(s1));
  cvdsq_pad_model pad2 (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .ana_i(a2), .sample_o(s2));

  task automatic results();
    if (n_fail == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    do @(posedge clk_sys_i); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  // Start one measurement and poll the busy bit until it drops
  task automatic run(input logic [11:0] a, input logic [31:0] en, input int b);
    int i;
    wr(a, en);
    n_iso = 0; n_acq = 0; n_conv = 0; n_bad = 0; n_skew = 0;
    pol.delete();
    wr(a, en | (32'h1 << b));
    pl = 1'b1;
    for (i = 0; i < 300 && pl; i++) begin
      xfer(1'b0, a, 32'h0);
      pl = r[b];
    end
    repeat (2) @(posedge clk_sys_i);
  endtask

  // Phase monitor on converter 1, skew monitor between converters
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      results();
    end
    if (a1.hold_isolate && !prev_iso) begin
      pol.push_back(a1.hold_to_vdd);
      g_pre = a1.grd_a_o;
    end
    if (!a1.hold_isolate && prev_iso) begin
      acq_on = 1'b1;
      g_acq  = a1.grd_a_o;
    end
    if (a1.conv_start) acq_on = 1'b0;
    n_iso  += a1.hold_isolate;
    n_conv += a1.conv_start;
    n_acq  += acq_on;
    if (!a1.conv_start && a1.hold_isolate !== a1.pad_drive_oe) n_bad++;
    if (a1.conv_start !== a2.conv_start) n_skew++;
    prev_iso = a1.hold_isolate;
  end

  initial begin : main
    logic [31:0] v0;
    logic        last;
    int          i;
    repeat (6) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    for (i = 0; i <= 12; i++) begin
      xfer(1'b0, 12'(4 * i), 32'h0);
      `CHK("reset word", cvdsq_pkg::RST_WORD, r)
      `CHK("mapped err", 1'b0, e)
    end
    xfer(1'b0, 12'h040, 32'h0);
    `CHK("unmapped err", 1'b1, e)
    `CHK("unmapped data", 32'h0, r)
    // Single run with guard drive and a channel change first
    wr(cvdsq_pkg::OFF_SEQ1, 32'h0024_0305);
    wr(cvdsq_pkg::OFF_CTRL0_1, 32'h15);
    repeat (8) @(posedge clk_sys_i);
    `CHK("channel", 5'h05, ch1)
    run(cvdsq_pkg::OFF_CTRL0_1, 32'h15, 1);
    `CHK("pre cycles", 5, n_iso)
    `CHK("acq cycles", 3, n_acq)
    `CHK("conv cycles", cvdsq_pkg::CONV_CYCLES, n_conv)
    `CHK("pad drive", 0, n_bad)
    `CHK("guard flips", 1'b1, g_pre ^ g_acq)
    `CHK("idle isolate", 1'b0, a1.hold_isolate)
    `CHK("guard oe", 2'b01, {a1.grd_b_oe, a1.grd_a_oe})
    xfer(1'b0, cvdsq_pkg::OFF_RES1_0, 32'h0);
    `CHK("result", pol[0] ? 32'h2A5 : 32'h15A, r)
    xfer(1'b0, cvdsq_pkg::OFF_IRQ_STAT, 32'h0);
    `CHK("done flag", 1'b1, r[0])
    `CHK("irq masked", 1'b0, irq)
    wr(cvdsq_pkg::OFF_IRQ_MASK, 32'h1);
    @(posedge clk_sys_i);
    `CHK("irq on", 1'b1, irq)
    wr(cvdsq_pkg::OFF_IRQ_STAT, 32'h1);
    @(posedge clk_sys_i);
    `CHK("irq off", 1'b0, irq)
    xfer(1'b0, cvdsq_pkg::OFF_IRQ_STAT, 32'h0);
    `CHK("stat clear", 32'h0, r)
    // Double sample, second run inverted
    wr(cvdsq_pkg::OFF_SEQ1, 32'h0003_0102);
    run(cvdsq_pkg::OFF_CTRL0_1, 32'h1, 1);
    `CHK("dbl conv", 2 * cvdsq_pkg::CONV_CYCLES, n_conv)
    `CHK("dbl pre", 4, n_iso)
    `CHK("runs", 2, pol.size())
    `CHK("inverted", 1'b1, pol[0] ^ pol[1])
    last = pol[1];
    xfer(1'b0, cvdsq_pkg::OFF_RES1_0, 32'h0);
    v0 = r;
    xfer(1'b0, cvdsq_pkg::OFF_RES1_1, 32'h0);
    `CHK("second set", v0 ^ 32'h3FF, r)
    // Double sample, no precharge: held charge is converted twice
    wr(cvdsq_pkg::OFF_SEQ1, 32'h0001_0400);
    run(cvdsq_pkg::OFF_CTRL0_1, 32'h1, 1);
    `CHK("no pre", 0, n_iso)
    `CHK("dbl conv 2", 2 * cvdsq_pkg::CONV_CYCLES, n_conv)
    xfer(1'b0, cvdsq_pkg::OFF_RES1_1, 32'h0);
    `CHK("held charge", last ? 32'h2A5 : 32'h15A, r)
    // Both converters from the common start bit
    wr(cvdsq_pkg::OFF_IRQ_STAT, 32'hFFFF_FFFF);
    wr(cvdsq_pkg::OFF_SEQ1, 32'h0000_0203);
    wr(cvdsq_pkg::OFF_SEQ2, 32'h0000_0203);
    wr(cvdsq_pkg::OFF_CTRL0_1, 32'h1);
    wr(cvdsq_pkg::OFF_CTRL0_2, 32'h1);
    run(cvdsq_pkg::OFF_COMMON, 32'h0, cvdsq_pkg::COM_GO_ALL_BIT);
    `CHK("skew", 0, n_skew)
    `CHK("conv both", cvdsq_pkg::CONV_CYCLES, n_conv)
    xfer(1'b0, cvdsq_pkg::OFF_IRQ_STAT, 32'h0);
    `CHK("both done", 2'b11, r[1:0])
    // Reset in the middle of a precharge
    wr(cvdsq_pkg::OFF_SEQ1, 32'h0000_0A0A);
    wr(cvdsq_pkg::OFF_CTRL0_1, 32'h3);
    repeat (3) @(posedge clk_sys_i);
    // Clock enable low must freeze the precharge count
    ce <= 1'b0;
    xfer(1'b0, cvdsq_pkg::OFF_PHASE, 32'h0);
    `CHK("frozen pre", 32'h1, r)
    repeat (20) @(posedge clk_sys_i);
    xfer(1'b0, cvdsq_pkg::OFF_PHASE, 32'h0);
    `CHK("still pre", 32'h1, r)
    ce <= 1'b1;
    nrst_i <= 1'b0;
    @(posedge clk_sys_i);
    `CHK("rst isolate", 1'b0, a1.hold_isolate)
    `CHK("rst conv", 1'b0, a1.conv_start)
    nrst_i <= 1'b1;
    xfer(1'b0, cvdsq_pkg::OFF_CTRL0_1, 32'h0);
    `CHK("rst busy", 32'h0, r)
    results();
  end
endmodule // testbench
